// >>> uf_pkg.sv
// Purpose: shared constants for the uart fifo and interrupt path
// Assumes: 32-bit avalon-mm slave, byte addresses, one register per word
// Notes: register indices times four give the byte address
package uf_pkg;
    localparam int unsigned DEPTH = 16;
    localparam logic [5:0] IDX_DATA = 6'h00;
    localparam logic [5:0] IDX_IER = 6'h01;
    localparam logic [5:0] IDX_IIR_FCR = 6'h02;
    localparam logic [5:0] IDX_MCR = 6'h04;
    localparam logic [5:0] IDX_STAT = 6'h08;
    localparam logic [5:0] IDX_CHAR = 6'h09;
    localparam logic [7:0] FCR_RST = 8'h00;
    localparam logic [3:0] IER_RST = 4'h0;
    localparam logic [7:0] MCR_RST = 8'h00;
    localparam logic [15:0] CHAR_CYC_RST = 16'h0823;
    localparam int unsigned FCR_EN = 0;
    localparam int unsigned FCR_RX_CLR = 1;
    localparam int unsigned FCR_TX_CLR = 2;
    localparam int unsigned FCR_DMA = 3;
    localparam int unsigned MCR_AUX2 = 3;
    localparam int unsigned TMO_CHARS = 4;
    localparam logic [3:0] IID_NONE = 4'h1;
    localparam logic [3:0] IID_LINE = 4'h6;
    localparam logic [3:0] IID_RX = 4'h4;
    localparam logic [3:0] IID_TMO = 4'hc;
    localparam logic [3:0] IID_TX = 4'h2;
    localparam logic [3:0] IID_MODEM = 4'h0;
endpackage

// >>> uf_tmo_if.sv
// Purpose: carrier between the register core and the receive timeout timer
// Assumes: single clock domain
// Notes: armed is a level, activity a one-cycle pulse
`timescale 1ns/1ps
interface uf_tmo_if;
    logic armed;
    logic activity;
    logic [15:0] char_cycles;
    logic fired;
    modport core (output armed, output activity, output char_cycles, input fired);
    modport timer (input armed, input activity, input char_cycles, output fired);
endinterface

// >>> uf_tmo.sv
// Purpose: receive timeout timer, four character times of fifo silence
// Assumes: char_cycles is nonzero
// Notes: count saturates so the flag stays until a read, a new character or a receive fifo clear
`timescale 1ns/1ps
module uf_tmo (
    input wire logic i_clk,
    input wire logic i_rst_b,
    uf_tmo_if.timer tmo
);
    import uf_pkg::*;
    logic [17:0] cnt_q;
    logic [17:0] cnt_d;
    logic fired_q;
    logic fired_d;
    logic [17:0] limit;

    always_comb begin
        limit = 18'(tmo.char_cycles) * 18'(TMO_CHARS);
        cnt_d = cnt_q;
        fired_d = fired_q;
        if (!tmo.armed || tmo.activity) begin // R8
            cnt_d = '0;
            fired_d = 1'b0;
        end else if (cnt_q >= limit - 18'h1) begin
            fired_d = 1'b1; // R8
        end else begin
            cnt_d = cnt_q + 18'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q <= '0;
            fired_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            fired_q <= fired_d;
        end
    end

    assign tmo.fired = fired_q;
endmodule

// >>> uf_core.sv
// Purpose: uart fifo, interrupt and dma request path with avalon-mm registers
// Assumes: receiver and transmitter framing logic sit outside on the same clock
// Notes: fifos act one deep until software enables them
// Contract
// R1 - power up in character mode, fifos off
// R2 - raise receive interrupt after delay below trigger
// R3 - four low enable bits gate four sources
// R4 - control bit three drives auxiliary output
// R5 - interrupt output is level, held while pending
// R6 - host clears enables on entry, restores on exit
// R7 - separate receive and transmit dma requests, two modes
// R8 - timeout after four idle character times
// R9 - host keeps fifo enable set on writes
// R10 - identification top bits read one in fifo mode
// R11 - single mode receive request while fifo nonempty
// R12 - interrupt drops once nothing enabled pends
`timescale 1ns/1ps
module uf_core #(
    parameter int unsigned DEPTH = uf_pkg::DEPTH
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [5:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    output logic o_tx_valid,
    output logic [7:0] o_tx_data,
    input wire logic i_tx_ready,
    input wire logic i_modem_change,
    output logic o_interrupt_output,
    output logic o_aux_output_two,
    output logic o_receive_dma_request,
    output logic o_transmit_dma_request
);
    import uf_pkg::*;
    localparam int unsigned AW = $clog2(DEPTH);

    // trigger level fourteen needs at least fourteen entries, sixteen is the smallest power of two that holds them
    if (DEPTH < 16 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two of at least sixteen");
    end

    // ****************************************************
    // helpers
    // ****************************************************
    function automatic logic [AW:0] trig_level(input logic [1:0] sel, input logic en);
        logic [AW:0] lvl;
        lvl = (AW+1)'(1);
        if (en) begin
            case (sel)
                2'h0: lvl = (AW+1)'(1);
                2'h1: lvl = (AW+1)'(4);
                2'h2: lvl = (AW+1)'(8);
                default: lvl = (AW+1)'(14);
            endcase
        end
        return lvl;
    endfunction

    // ****************************************************
    // state
    // ****************************************************
    logic [7:0] rx_mem [DEPTH];
    logic [7:0] tx_mem [DEPTH];
    logic [AW-1:0] rx_rd_q, rx_rd_d, rx_wr_q, rx_wr_d, tx_rd_q, tx_rd_d, tx_wr_q, tx_wr_d;
    logic [AW:0] rx_cnt_q, rx_cnt_d, tx_cnt_q, tx_cnt_d;
    logic [7:0] fcr_q, fcr_d, mcr_q, mcr_d;
    logic [3:0] ier_q, ier_d, stat_q, stat_d;
    logic [15:0] char_q, char_d;
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic req, take, rx_push, rx_pop, tx_push, tx_pop, fifo_en, rx_clr, tx_clr;
    logic [AW:0] eff_depth;
    logic [3:0] events, pend;
    logic [3:0] iid;
    logic [7:0] iir;
    logic rx_req_hold_q;
    uf_tmo_if tmo_bus ();

    uf_tmo u_tmo (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .tmo(tmo_bus.timer)
    );

    // ****************************************************
    // bus, fifos, interrupts
    // ****************************************************
    always_comb begin
        req = i_avs_read | i_avs_write;
        ack_d = req & ~ack_q;
        take = req & ack_q;
        fifo_en = fcr_q[FCR_EN];
        eff_depth = fifo_en ? (AW+1)'(DEPTH) : (AW+1)'(1); // R1
        rx_push = i_rx_valid && (rx_cnt_q < eff_depth);
        rx_pop = take && i_avs_read && (i_avs_address[5:2] == IDX_DATA[3:0]) && (rx_cnt_q != '0);
        tx_push = take && i_avs_write && (i_avs_address[5:2] == IDX_DATA[3:0]) && (tx_cnt_q < eff_depth);
        tx_pop = (tx_cnt_q != '0) && i_tx_ready;
        fcr_d = fcr_q;
        ier_d = ier_q;
        mcr_d = mcr_q;
        char_d = char_q;
        rx_clr = 1'b0;
        tx_clr = 1'b0;
        stat_d = stat_q;
        if (take && i_avs_write) begin
            case (i_avs_address[5:2])
                IDX_IER[3:0]: ier_d = i_avs_writedata[3:0]; // R3
                IDX_IIR_FCR[3:0]: begin
                    fcr_d = i_avs_writedata[7:0];
                    // any change of enable empties both fifos, stale bytes never leak across modes
                    rx_clr = i_avs_writedata[FCR_RX_CLR] | (i_avs_writedata[FCR_EN] ^ fifo_en);
                    tx_clr = i_avs_writedata[FCR_TX_CLR] | (i_avs_writedata[FCR_EN] ^ fifo_en);
                end
                IDX_MCR[3:0]: mcr_d = i_avs_writedata[7:0];
                IDX_STAT[3:0]: stat_d = stat_q & ~i_avs_writedata[3:0];
                IDX_CHAR[3:0]: char_d = i_avs_writedata[15:0];
                default: ;
            endcase
        end
        rx_rd_d = rx_clr ? '0 : rx_rd_q + AW'(rx_pop);
        rx_wr_d = rx_clr ? '0 : rx_wr_q + AW'(rx_push);
        rx_cnt_d = rx_clr ? '0 : rx_cnt_q + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
        tx_rd_d = tx_clr ? '0 : tx_rd_q + AW'(tx_pop);
        tx_wr_d = tx_clr ? '0 : tx_wr_q + AW'(tx_push);
        tx_cnt_d = tx_clr ? '0 : tx_cnt_q + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
        // levels keep setting their bit, so set wins over a clear in the same cycle
        events[0] = (rx_cnt_q >= trig_level(fcr_q[7:6], fifo_en)) | tmo_bus.fired; // R2
        events[1] = (tx_cnt_q == '0);
        events[2] = i_rx_valid & ~(rx_cnt_q < eff_depth);
        events[3] = i_modem_change;
        stat_d = stat_d | events;
        pend = stat_q & ier_q; // R3
        if (pend[2]) begin
            iid = IID_LINE;
        end else if (pend[0]) begin
            iid = tmo_bus.fired ? IID_TMO : IID_RX;
        end else if (pend[1]) begin
            iid = IID_TX;
        end else if (pend[3]) begin
            iid = IID_MODEM;
        end else begin
            iid = IID_NONE;
        end
        iir = {fifo_en, fifo_en, 2'h0, iid}; // R10
        rdata_d = rdata_q;
        if (req && !ack_q) begin
            case (i_avs_address[5:2])
                IDX_DATA[3:0]: rdata_d = {24'h0, (rx_cnt_q != '0) ? rx_mem[rx_rd_q] : 8'h00};
                IDX_IER[3:0]: rdata_d = {28'h0, ier_q};
                IDX_IIR_FCR[3:0]: rdata_d = {24'h0, iir};
                IDX_MCR[3:0]: rdata_d = {24'h0, mcr_q};
                IDX_STAT[3:0]: rdata_d = {28'h0, stat_q};
                IDX_CHAR[3:0]: rdata_d = {16'h0, char_q};
                default: rdata_d = 32'h0;
            endcase
        end
    end

    assign tmo_bus.armed = fifo_en && (rx_cnt_q != '0); // R8
    assign tmo_bus.activity = rx_push | rx_pop; // R8
    assign tmo_bus.char_cycles = char_q;

    always_ff @(posedge i_clk) begin
        if (rx_push) begin
            rx_mem[rx_wr_q] <= i_rx_data;
        end
        if (tx_push) begin
            tx_mem[tx_wr_q] <= i_avs_writedata[7:0];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fcr_q <= FCR_RST; // R1
            ier_q <= IER_RST;
            mcr_q <= MCR_RST;
            char_q <= CHAR_CYC_RST;
            stat_q <= 4'h0;
            ack_q <= 1'b0;
            rdata_q <= 32'h0;
            rx_rd_q <= '0;
            rx_wr_q <= '0;
            rx_cnt_q <= '0;
            tx_rd_q <= '0;
            tx_wr_q <= '0;
            tx_cnt_q <= '0;
        end else begin
            fcr_q <= fcr_d;
            ier_q <= ier_d;
            mcr_q <= mcr_d;
            char_q <= char_d;
            stat_q <= stat_d;
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            rx_rd_q <= rx_rd_d;
            rx_wr_q <= rx_wr_d;
            rx_cnt_q <= rx_cnt_d;
            tx_rd_q <= tx_rd_d;
            tx_wr_q <= tx_wr_d;
            tx_cnt_q <= tx_cnt_d;
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************
    assign o_avs_waitrequest = req & ~ack_q;
    assign o_avs_readdata = rdata_q;
    assign o_tx_valid = (tx_cnt_q != '0);
    assign o_tx_data = tx_mem[tx_rd_q];
    // level, not pulse: an edge-triggered controller needs the host to toggle enables
    assign o_interrupt_output = |(stat_q & ier_q); // R5 R12
    assign o_aux_output_two = mcr_q[MCR_AUX2]; // R4
    // single mode: any byte; multi mode: trigger or timeout, both drop only when empty
    assign o_receive_dma_request = (fifo_en && fcr_q[FCR_DMA]) ? // R7
        ((rx_cnt_q != '0) && (events[0] || rx_req_hold_q)) : (rx_cnt_q != '0); // R11
    assign o_transmit_dma_request = (fifo_en && fcr_q[FCR_DMA]) ? (tx_cnt_q < eff_depth) : (tx_cnt_q == '0); // R7

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_req_hold_q <= 1'b0;
        end else begin
            rx_req_hold_q <= o_receive_dma_request;
        end
    end
endmodule

// >>> uf_assertions.sv
// Purpose: port checks for the uart interrupt path
// Assumes: one clock, async active-low reset
// Notes: fcr and ier shadows are rebuilt from accepted bus writes
`timescale 1ns/1ps
module uf_chk import uf_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [5:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic i_rx_valid,
    input wire logic o_tx_valid,
    input wire logic o_interrupt_output,
    input wire logic o_aux_output_two,
    input wire logic o_receive_dma_request,
    input wire logic o_transmit_dma_request
);
    // ****
    // shadows and checks
    // ****
    logic [3:0] ier_q;
    logic fen_q;
    logic dma_q;
    wire logic wacc = i_avs_write && !o_avs_waitrequest;
    wire logic racc = i_avs_read && !o_avs_waitrequest;
    wire logic [3:0] idx = i_avs_address[5:2];
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ier_q <= IER_RST;
            fen_q <= FCR_RST[FCR_EN];
            dma_q <= FCR_RST[FCR_DMA];
        end else if (wacc && idx == IDX_IER[3:0]) begin
            ier_q <= i_avs_writedata[3:0];
        end else if (wacc && idx == IDX_IIR_FCR[3:0]) begin
            fen_q <= i_avs_writedata[FCR_EN];
            dma_q <= i_avs_writedata[FCR_DMA];
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    sequence s_taken;
        o_avs_waitrequest ##1 !o_avs_waitrequest;
    endsequence
    sequence s_mcr_wr;
        wacc && idx == IDX_MCR[3:0];
    endsequence
    req_answer_a: assert property ($rose(i_avs_read || i_avs_write) |-> s_taken)
        else $error("request not answered after one wait cycle");
    aux_follows_a: assert property (s_mcr_wr |=> o_aux_output_two == $past(i_avs_writedata[MCR_AUX2]))
        else $error("aux output does not follow bit three");
    aux_holds_a: assert property (!(wacc && idx == IDX_MCR[3:0]) |=> $stable(o_aux_output_two))
        else $error("aux output moved without a write");
    level_hold_a: assert property (o_interrupt_output && !wacc |=> o_interrupt_output)
        else $error("interrupt dropped with no write");
    enable_clear_a: assert property (wacc && idx == IDX_IER[3:0] && i_avs_writedata[3:0] == 4'h0 |=> !o_interrupt_output)
        else $error("interrupt stays after enables cleared");
    quiet_masked_a: assert property (ier_q == 4'h0 |-> !o_interrupt_output)
        else $error("interrupt with all enables clear");
    tx_source_a: assert property (ier_q[1] && !o_tx_valid && !wacc |=> o_interrupt_output)
        else $error("tx empty source not raised");
    fifo_ident_a: assert property (racc && idx == IDX_IIR_FCR[3:0] |-> o_avs_readdata[7:6] == {2{fen_q}})
        else $error("identification top bits wrong");
    rx_single_a: assert property (i_rx_valid && !dma_q && !wacc && !racc |=> o_receive_dma_request)
        else $error("rx request missing after byte");
    tx_empty_req_a: assert property (!o_tx_valid |-> o_transmit_dma_request)
        else $error("tx request low while tx empty");
endmodule

// >>> uf_far_model.sv
// Purpose: far side: serial drain, interrupt buffer, edge-triggered controller
// Assumes: one clock
// Notes: drain stalls three cycles of four so the tx side sees back-pressure
`timescale 1ns/1ps
module uf_far (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_tx_valid,
    input wire logic i_irq,
    input wire logic i_aux,
    output logic o_tx_ready,
    output int o_edges
);
    logic [1:0] ph_q;
    logic line_q;
    wire logic line = i_irq & i_aux;
    assign o_tx_ready = i_tx_valid & (ph_q == 2'h3);
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ph_q <= 2'h0;
            line_q <= 1'h0;
            o_edges <= 0;
        end else begin
            ph_q <= ph_q + 2'h1;
            line_q <= line;
            // controller only counts rising edges, a held level is missed
            if (line && !line_q) o_edges <= o_edges + 1;
        end
    end
endmodule

// >>> test_uart_fifo_interrupt_path.sv
// Purpose: self-checking bench for the uart interrupt path
// Assumes: the design answers every request
// Notes: char time cut to 2 cycles to keep the timeout short
`timescale 1ns/1ps
module test_uart_fifo_interrupt_path;
    import uf_pkg::*;
    logic i_clk = 1'h0, i_rst_b = 1'h0, rd = 1'h0, wr = 1'h0, rxv = 1'h0, mdm = 1'h0;
    logic [5:0] adr = 6'h0;
    logic [31:0] wd = 32'h0, q, rdat;
    logic [7:0] rxd = 8'h0, b [4];
    logic [7:0] txd, t [4];
    int ti = 0;
    logic [15:0] s = 16'h0010;
    logic [3:0] iid [4];
    logic wt, irq, aux, rxr, txr, txv, transmit_dma_request;
    int mismatches = 0, checks_done = 0, edges, e0;
    always #25 i_clk = ~i_clk;
    uf_core u_dut (.i_clk, .i_rst_b, .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .o_avs_readdata(rdat), .o_avs_waitrequest(wt), .i_rx_valid(rxv),
        .i_rx_data(rxd), .o_tx_valid(txv), .o_tx_data(txd), .i_tx_ready(transmit_dma_request), .i_modem_change(mdm),
        .o_interrupt_output(irq), .o_aux_output_two(aux), .o_receive_dma_request(rxr),
        .o_transmit_dma_request(txr));
    uf_far u_far (.i_clk, .i_rst_b, .i_tx_valid(txv), .i_irq(irq), .i_aux(aux), .o_tx_ready(transmit_dma_request),
        .o_edges(edges));
    function automatic logic [15:0] nx(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic fail(input string m);
        mismatches++;
        $display("MISMATCH %0t %s", $time, m);
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
        checks_done++;
        if (g !== e) fail(m);
    endtask
    task automatic pin(input logic g, input logic e, input string m);
        checks_done++;
        if (g !== e) fail(m);
    endtask
    task automatic st;
        @(negedge i_clk);
    endtask
    // held until waitrequest is seen low at an edge
    // only the watchdog ends a wait that is never answered
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge i_clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge i_clk);
        end while (wt !== 1'h0);
        q = rdat;
        rd <= 1'h0;
        wr <= 1'h0;
    endtask
    task automatic ev(input logic m, input logic [7:0] v);
        @(posedge i_clk);
        mdm <= m;
        rxv <= !m;
        rxd <= v;
        @(posedge i_clk);
        mdm <= 1'h0;
        rxv <= 1'h0;
    endtask
    task automatic end_of_test;
        if (mismatches == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // every byte the drain takes must come out in write order
    always @(negedge i_clk) begin
        if (txv && transmit_dma_request) begin
            cmp({24'h0, txd}, {24'h0, t[ti]}, "tx byte");
            ti++;
        end
    end
    initial begin
        #2000000;
        fail("timeout");
        end_of_test;
    end
    initial begin
        iid = '{IID_RX, IID_TX, IID_LINE, IID_MODEM};
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'h1;
        bus(1'h0, 6'h08, 32'h0);
        cmp(q & 32'hcf, {28'h0, IID_NONE}, "iir at reset");
        st;
        pin(irq | aux | rxr | !txr, 1'h0, "pins at reset");
        // odd passes flip bit three so the aux output is seen both ways
        for (int j = 0; j < 4; j++) begin
            s = nx(s) ^ 16'(j << 3);
            bus(1'h1, 6'h10, {16'h0, s});
            st;
            pin(aux, s[3], "aux output");
        end
        for (int k = 0; k < 4; k++) begin
            s = nx(s);
            bus(1'h1, 6'h20, 32'hf);
            bus(1'h1, 6'h04, 32'h1 << k);
            st;
            pin(irq, k == 1, "idle source");
            if (k != 1) ev(k == 3, s[7:0]);
            if (k == 2) ev(1'h0, s[7:0]);
            repeat (6) @(posedge i_clk);
            st;
            pin(irq, 1'h1, "source held");
            bus(1'h0, 6'h08, 32'h0);
            cmp(q & 32'hf, {28'h0, iid[k]}, "iir code");
            bus(1'h0, 6'h00, 32'h0);
            if (k == 0) cmp(q, {24'h0, s[7:0]}, "rx byte");
            bus(1'h1, 6'h20, 32'hf);
            st;
            pin(irq, k == 1, "cleared source");
            bus(1'h1, 6'h04, 32'h0);
            st;
            pin(irq, 1'h0, "enables cleared");
        end
        // edge-triggered controller needs enables dropped and restored
        bus(1'h1, 6'h10, 32'h8);
        e0 = edges;
        bus(1'h1, 6'h04, 32'h2);
        bus(1'h1, 6'h04, 32'h0);
        bus(1'h1, 6'h04, 32'h2);
        repeat (2) @(posedge i_clk);
        cmp(32'(edges - e0), 32'h2, "fresh edges");
        bus(1'h1, 6'h04, 32'h0);
        bus(1'h1, 6'h24, 32'h2);
        bus(1'h1, 6'h08, 32'hc1);
        bus(1'h1, 6'h04, 32'h1);
        s = nx(s);
        ev(1'h0, s[7:0]);
        // four char times of two cycles: fired after eight, status one later
        repeat (6) @(posedge i_clk);
        st;
        pin(irq, 1'h0, "early timeout");
        pin(rxr, 1'h1, "rx request single");
        repeat (4) @(posedge i_clk);
        st;
        pin(irq, 1'h1, "timeout");
        bus(1'h0, 6'h08, 32'h0);
        cmp(q & 32'hcf, {24'h0, 4'hc, IID_TMO}, "iir timeout");
        bus(1'h0, 6'h00, 32'h0);
        cmp(q, {24'h0, s[7:0]}, "rx byte");
        st;
        pin(rxr, 1'h0, "rx request empty");
        bus(1'h1, 6'h20, 32'h1);
        st;
        pin(irq, 1'h0, "timeout cleared");
        // writes every third cycle outrun the drain, so only a real fifo keeps all four
        for (int i = 0; i < 4; i++) begin
            s = nx(s);
            t[i] = s[7:0];
            bus(1'h1, 6'h00, {24'h0, t[i]});
            st;
            pin(txr, 1'h0, "tx request busy");
        end
        bus(1'h1, 6'h08, 32'h49);
        for (int i = 0; i < 4; i++) begin
            st;
            pin(rxr, 1'h0, "below trigger");
            s = nx(s);
            b[i] = s[7:0];
            ev(1'h0, b[i]);
        end
        st;
        pin(rxr, 1'h1, "at trigger");
        pin(txr, 1'h1, "tx not full");
        for (int i = 0; i < 4; i++) begin
            bus(1'h0, 6'h00, 32'h0);
            cmp(q, {24'h0, b[i]}, "rx order");
        end
        st;
        pin(rxr, 1'h0, "drained");
        cmp(32'(ti), 32'h4, "tx count");
        end_of_test;
    end
endmodule
bind uf_core uf_chk u_chk (.i_clk, .i_rst_b, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .o_avs_readdata, .o_avs_waitrequest, .i_rx_valid, .o_tx_valid, .o_interrupt_output, .o_aux_output_two,
    .o_receive_dma_request, .o_transmit_dma_request);
